// >>> oled_seq_pkg.sv
// Shared constants, offsets and types for the reset/power sequencer
package oled_seq_pkg;

  // Register port widths
  localparam int DW = 8;
  localparam int AW = 3;

  // Register offsets (word index on the plain register port)
  localparam logic [AW-1:0] CTRL_OFS     = 3'h0;
  localparam logic [AW-1:0] GLYPH_OFS    = 3'h1;
  localparam logic [AW-1:0] ICON_OFS     = 3'h2;
  localparam logic [AW-1:0] TEXT_OFS     = 3'h3;
  localparam logic [AW-1:0] LINE_OFS     = 3'h4;
  localparam logic [AW-1:0] COL_OFS      = 3'h5;
  localparam logic [AW-1:0] CONTRAST_OFS = 3'h6;
  localparam logic [AW-1:0] STATUS_OFS   = 3'h7;

  // Control register bit positions
  localparam int DISP_BIT  = 0;
  localparam int CURS_BIT  = 1;
  localparam int BLINK_BIT = 2;
  localparam int PWRDN_BIT = 3;
  localparam int FONT_BIT  = 4;
  localparam int SHIFT_BIT = 5;
  localparam int SCAN_BIT  = 6;

  // Status register bit positions
  localparam int READY_BIT = 0;
  localparam int HOLD_BIT  = 1;

  // Field widths
  localparam int CTRL_W     = 7;
  localparam int GLYPH_W    = 6;
  localparam int ICON_W     = 6;
  localparam int TEXT_W     = 7;
  localparam int LINE_W     = 7;
  localparam int COL_W      = 7;
  localparam int CONTRAST_W = 8;

  // Values after reset
  localparam logic [CTRL_W-1:0]     CTRL_RST     = 7'h00;
  localparam logic [GLYPH_W-1:0]    GLYPH_RST    = 6'h00;
  localparam logic [ICON_W-1:0]     ICON_RST     = 6'h00;
  localparam logic [TEXT_W-1:0]     TEXT_RST     = 7'h00;
  localparam logic [LINE_W-1:0]     LINE_RST     = 7'h00;
  localparam logic [COL_W-1:0]      COL_RST      = 7'h00;
  localparam logic [CONTRAST_W-1:0] CONTRAST_RST = 8'h7F;
  localparam logic                  PIN_RST      = 1'h0;
  localparam logic [DW-1:0]         RDATA_RST    = 8'h00;
  localparam logic                  READY_RST    = 1'h0;

  // Active display configuration seen by the panel logic
  typedef struct packed {
    logic                  display_on;
    logic                  cursor_on;
    logic                  blink_on;
    logic                  power_down;
    logic                  font_wide;
    logic                  shift_en;
    logic                  scan_rev;
    logic [GLYPH_W-1:0]    glyph_addr;
    logic [ICON_W-1:0]     icon_addr;
    logic [TEXT_W-1:0]     text_addr;
    logic [LINE_W-1:0]     start_line;
    logic [COL_W-1:0]      col_addr;
    logic [CONTRAST_W-1:0] contrast;
  } cfg_s;

endpackage

// >>> pin_sync.sv
// Two-flop synchroniser for one pin input
`timescale 1ns/10ps
module pin_sync
  import oled_seq_pkg::*;
#(
  parameter logic RST = 1'h0
) (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic clk_en,
  input  wire logic pin,
  output logic      q
);

  logic meta_q;
  logic meta_d;
  logic q_d;

  // First stage is read only by the second
  always_comb begin
    meta_d = nrst ? pin : RST;
    q_d    = nrst ? meta_q : RST;
  end

  // Reset acts even while the enable is low
  always_ff @(posedge clk) begin
    if (!nrst || clk_en) begin
      meta_q <= meta_d;
      q      <= q_d;
    end
  end

endmodule // pin_sync

// >>> cfg_field.sv
// One configuration field with reset value and forced clear
`timescale 1ns/10ps
module cfg_field
  import oled_seq_pkg::*;
#(
  parameter int           W   = 8,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         clk_en,
  input  wire logic         clr,
  input  wire logic         load,
  input  wire logic [W-1:0] wdata,
  output logic      [W-1:0] q
);

  logic [W-1:0] d;

  // Clear beats a load; defaults hold while clear stays high
  always_comb begin
    if (!nrst || clr) begin
      d = RST;
    end else if (load) begin
      d = wdata;
    end else begin
      d = q;
    end
  end

  // Enable freezes the field, reset does not wait for it
  always_ff @(posedge clk) begin
    if (!nrst || clk_en) begin
      q <= d;
    end
  end

endmodule // cfg_field

// >>> oled_char_reset_power_seq.sv
// Reset defaults and configuration hold for the character display core
//
// Overview of operation
// - Init input active low; low forces reset
// - Held low: display, cursor, blink off; awake
// - Reset selects five-dot font, no shifting
// - Reset zeroes glyph and icon RAM pointers
// - Reset zeroes text buffer RAM pointer
// - Reset makes RAM address zero first line
// - Reset zeroes column address counter
// - Reset selects normal row driver scan direction
// - Reset loads contrast with value 7Fh
//
// The strobed register port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
module oled_char_reset_power_seq
  import oled_seq_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          nrst,
  input  wire logic          clk_en,
  input  wire logic          init_low_input,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic          wr,
  input  wire logic          rd,
  output logic      [DW-1:0] rdata,
  output logic               ready,
  output cfg_s               cfg
);

  // One clock domain; checks stand down while reset is low
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  // Synchronised pin level and derived hold
  logic init_sync;
  logic hold;
  logic take_wr;

  // Field registers
  logic [CTRL_W-1:0]     ctrl_q;
  logic [GLYPH_W-1:0]    glyph_q;
  logic [ICON_W-1:0]     icon_q;
  logic [TEXT_W-1:0]     text_q;
  logic [LINE_W-1:0]     line_q;
  logic [COL_W-1:0]      col_q;
  logic [CONTRAST_W-1:0] contrast_q;

  // Read path and status
  logic [DW-1:0] rdata_q;
  logic [DW-1:0] rdata_d;
  logic          ready_q;
  logic          ready_d;

  // Pin comes from outside the clock domain
  pin_sync #(
    .RST (PIN_RST)
  ) u_init_sync (
    .clk    (clk),
    .nrst   (nrst),
    .clk_en (clk_en),
    .pin    (init_low_input),
    .q      (init_sync)
  );

  // Low level on the pin forces the reset state
  assign hold    = ~init_sync;
  // Commands refused while the init input is held
  assign take_wr = wr & ~hold;

  // Display/cursor/blink off, awake, 5-dot font, no shift, normal scan
  cfg_field #(
    .W   (CTRL_W),
    .RST (CTRL_RST)
  ) u_ctrl (
    .clk    (clk),
    .nrst   (nrst),
    .clk_en (clk_en),
    .clr    (hold),
    .load   (take_wr && addr == CTRL_OFS),
    .wdata  (wdata[CTRL_W-1:0]),
    .q      (ctrl_q)
  );

  // User glyph RAM pointer
  cfg_field #(
    .W   (GLYPH_W),
    .RST (GLYPH_RST)
  ) u_glyph (
    .clk    (clk),
    .nrst   (nrst),
    .clk_en (clk_en),
    .clr    (hold),
    .load   (take_wr && addr == GLYPH_OFS),
    .wdata  (wdata[GLYPH_W-1:0]),
    .q      (glyph_q)
  );

  // Segment icon RAM pointer
  cfg_field #(
    .W   (ICON_W),
    .RST (ICON_RST)
  ) u_icon (
    .clk    (clk),
    .nrst   (nrst),
    .clk_en (clk_en),
    .clr    (hold),
    .load   (take_wr && addr == ICON_OFS),
    .wdata  (wdata[ICON_W-1:0]),
    .q      (icon_q)
  );

  // Text buffer RAM pointer
  cfg_field #(
    .W   (TEXT_W),
    .RST (TEXT_RST)
  ) u_text (
    .clk    (clk),
    .nrst   (nrst),
    .clk_en (clk_en),
    .clr    (hold),
    .load   (take_wr && addr == TEXT_OFS),
    .wdata  (wdata[TEXT_W-1:0]),
    .q      (text_q)
  );

  // First displayed line
  cfg_field #(
    .W   (LINE_W),
    .RST (LINE_RST)
  ) u_line (
    .clk    (clk),
    .nrst   (nrst),
    .clk_en (clk_en),
    .clr    (hold),
    .load   (take_wr && addr == LINE_OFS),
    .wdata  (wdata[LINE_W-1:0]),
    .q      (line_q)
  );

  // Column address counter
  cfg_field #(
    .W   (COL_W),
    .RST (COL_RST)
  ) u_col (
    .clk    (clk),
    .nrst   (nrst),
    .clk_en (clk_en),
    .clr    (hold),
    .load   (take_wr && addr == COL_OFS),
    .wdata  (wdata[COL_W-1:0]),
    .q      (col_q)
  );

  // Contrast level, mid-range after reset
  cfg_field #(
    .W   (CONTRAST_W),
    .RST (CONTRAST_RST)
  ) u_contrast (
    .clk    (clk),
    .nrst   (nrst),
    .clk_en (clk_en),
    .clr    (hold),
    .load   (take_wr && addr == CONTRAST_OFS),
    .wdata  (wdata[CONTRAST_W-1:0]),
    .q      (contrast_q)
  );

  // Read mux; data stand only in the cycle after the strobe
  always_comb begin
    rdata_d = RDATA_RST;
    ready_d = ~hold;
    if (rd) begin
      unique case (addr)
        CTRL_OFS:     rdata_d = {1'h0, ctrl_q};
        GLYPH_OFS:    rdata_d = {2'h0, glyph_q};
        ICON_OFS:     rdata_d = {2'h0, icon_q};
        TEXT_OFS:     rdata_d = {1'h0, text_q};
        LINE_OFS:     rdata_d = {1'h0, line_q};
        COL_OFS:      rdata_d = {1'h0, col_q};
        CONTRAST_OFS: rdata_d = contrast_q;
        STATUS_OFS: begin
          rdata_d[READY_BIT] = ready_q;
          rdata_d[HOLD_BIT]  = hold;
        end
      endcase
    end
  end

  // Read data and ready flag registers
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdata_q <= RDATA_RST;
      ready_q <= READY_RST;
    end else if (clk_en) begin
      rdata_q <= rdata_d;
      ready_q <= ready_d;
    end
  end

  // Outputs are flop values only, no logic between
  assign rdata = rdata_q;
  assign ready = ready_q;

  // Configuration as one struct towards the panel logic
  assign cfg.display_on = ctrl_q[DISP_BIT];
  assign cfg.cursor_on  = ctrl_q[CURS_BIT];
  assign cfg.blink_on   = ctrl_q[BLINK_BIT];
  assign cfg.power_down = ctrl_q[PWRDN_BIT];
  assign cfg.font_wide  = ctrl_q[FONT_BIT];
  assign cfg.shift_en   = ctrl_q[SHIFT_BIT];
  assign cfg.scan_rev   = ctrl_q[SCAN_BIT];
  assign cfg.glyph_addr = glyph_q;
  assign cfg.icon_addr  = icon_q;
  assign cfg.text_addr  = text_q;
  assign cfg.start_line = line_q;
  assign cfg.col_addr   = col_q;
  assign cfg.contrast   = contrast_q;

  // Checks on the reset state and command gating

  // Two enabled low samples of the pin raise the hold
  pin_hold_a: assert property (
    (clk_en && !init_low_input) [*2] |=> hold
  ) else $error("init pin low did not raise hold");

  // Visible elements blanked while held
  hold_blank_a: assert property (
    (hold && clk_en) |=>
      !cfg.display_on && !cfg.cursor_on && !cfg.blink_on
  ) else $error("display not blanked while held");

  // Power-down stays off while held
  hold_awake_a: assert property (
    (hold && clk_en) |=> !cfg.power_down
  ) else $error("power down set while held");

  // Narrow font and no shift while held
  font_default_a: assert property (
    (hold && clk_en) |=> !cfg.font_wide && !cfg.shift_en
  ) else $error("font or shift not at default");

  // Glyph and icon pointers cleared
  ram_ptr_a: assert property (
    (hold && clk_en) |=> cfg.glyph_addr == GLYPH_RST
      && cfg.icon_addr == ICON_RST
  ) else $error("glyph or icon pointer not cleared");

  // Text pointer cleared
  text_ptr_a: assert property (
    (hold && clk_en) |=> cfg.text_addr == TEXT_RST
  ) else $error("text pointer not cleared");

  // First line at RAM address zero
  start_line_a: assert property (
    (hold && clk_en) |=> cfg.start_line == LINE_RST
  ) else $error("start line not at zero");

  // Column counter cleared
  col_count_a: assert property (
    (hold && clk_en) |=> cfg.col_addr == COL_RST
  ) else $error("column counter not cleared");

  // Normal scan direction
  scan_dir_a: assert property (
    (hold && clk_en) |=> !cfg.scan_rev
  ) else $error("row scan reversed while held");

  // Contrast back to mid-range
  contrast_def_a: assert property (
    (hold && clk_en) |=> cfg.contrast == CONTRAST_RST
  ) else $error("contrast not at 7F while held");

  // Write while held leaves contrast at default
  held_write_a: assert property (
    (hold && clk_en && wr && addr == CONTRAST_OFS)
      |=> cfg.contrast == CONTRAST_RST
  ) else $error("write accepted while held");

  // Write after release is taken
  free_write_a: assert property (
    (!hold && clk_en && wr && addr == CONTRAST_OFS)
      |=> cfg.contrast == $past(wdata)
  ) else $error("contrast write lost after release");

  // Ready follows release one cycle later
  ready_flag_a: assert property (
    clk_en |=> ready == !$past(hold)
  ) else $error("ready does not follow hold");

  // Control write after release reaches the display-on flag
  ctrl_write_a: assert property (
    (!hold && clk_en && wr && addr == CTRL_OFS)
      |=> cfg.display_on == $past(wdata[DISP_BIT])
  ) else $error("control write lost after release");

  // Status read while held shows the hold bit
  held_status_a: assert property (
    (hold && clk_en && rd && addr == STATUS_OFS) |=> rdata[HOLD_BIT]
  ) else $error("hold bit not shown while held");

endmodule // oled_char_reset_power_seq

// >>> host_model.sv
// Host model: register master, init pin and supply switching
`timescale 1ns/10ps
module host_model
  import oled_seq_pkg::*;
#(
  parameter int SETTLE = 20
) (
  input  wire logic          clk,
  input  wire logic          ready,
  input  wire logic [DW-1:0] rdata,
  output logic               init_low_input,
  output logic [AW-1:0]      addr,
  output logic [DW-1:0]      wdata,
  output logic               wr,
  output logic               rd,
  output logic               logic_pwr,
  output logic               panel_pwr
);
  // Idle at time zero: pin released, supplies off
  initial begin
    init_low_input = 1'h1;
    {wr, rd, logic_pwr, panel_pwr} = 4'h0;
    addr  = 3'h0;
    wdata = 8'h00;
  end

  // Write; released lines show the inverse so stale values never match
  task automatic put(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'h1;
    @(posedge clk);
    wr    <= 1'h0;
    addr  <= ~a;
    wdata <= ~d;
  endtask

  // Read; data taken in the one cycle after the strobe
  task automatic get(input logic [AW-1:0] a, output logic [DW-1:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'h1;
    @(posedge clk);
    rd   <= 1'h0;
    addr <= ~a;
    #1 d = rdata;
  endtask

  // Init pin level, changed just after an edge
  task automatic pin(input logic v);
    @(posedge clk);
    init_low_input <= v;
  endtask

  // Shortened stand-in for the 100 ms panel wait
  task automatic settle();
    repeat (SETTLE) @(posedge clk);
  endtask

  // Logic on, off, init, clear, panel on, wait, on
  task automatic power_up();
    @(posedge clk);
    logic_pwr <= 1'h1;
    put(CTRL_OFS, 8'h00);
    pin(1'h0);
    repeat (3) @(posedge clk);
    pin(1'h1);
    // Ready is looked at once it has settled, not at the edge
    #1;
    for (int i = 0; i < 8 && ready !== 1'h1; i++) begin
      @(posedge clk);
      #1;
    end
    put(TEXT_OFS, 8'h00);
    @(posedge clk);
    panel_pwr <= 1'h1;
    settle();
    put(CTRL_OFS, 8'h01);
  endtask

  // Off, panel down, discharge wait, then logic; never logic first
  task automatic power_down();
    put(CTRL_OFS, 8'h00);
    @(posedge clk);
    panel_pwr <= 1'h0;
    settle();
    logic_pwr <= 1'h0;
  endtask
endmodule // host_model

// >>> oled_char_reset_power_seq_test.sv
// Self-checking bench for the reset defaults and init hold
`timescale 1ns/10ps
module oled_char_reset_power_seq_test
  import oled_seq_pkg::*;
;
  logic          clk;
  logic          nrst;
  logic          clk_en;
  logic          init_low_input;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic          wr;
  logic          rd;
  logic [DW-1:0] rdata;
  logic          ready;
  cfg_s          cfg;
  logic          logic_pwr;
  logic          panel_pwr;
  cfg_s          c;
  logic [DW-1:0] rv;
  int            n;
  int            n_fail = 0;
  int            n_tests = 0;

  oled_char_reset_power_seq dut (.clk(clk), .nrst(nrst), .clk_en(clk_en),
    .init_low_input(init_low_input), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .ready(ready), .cfg(cfg));

  host_model h (.clk(clk), .ready(ready), .rdata(rdata),
    .init_low_input(init_low_input), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .logic_pwr(logic_pwr), .panel_pwr(panel_pwr));

  // 125 MHz clock
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Edges until ready, bounded so a stuck flag cannot hang
  task automatic wait_ready();
    for (n = 1; n < 10; n++) begin
      @(posedge clk);
      #1;
      if (ready === 1'h1) break;
    end
  endtask

  function automatic cfg_s dflt();
    cfg_s d;
    d = '0;
    d.contrast = 8'h7F;
    return d;
  endfunction

  task automatic t_defaults();
    chk(cfg, dflt());
    for (int i = 0; i < 8; i++) begin
      h.get(i[AW-1:0], rv);
      chk(rv, i == 6 ? 8'h7F : i == 7 ? 8'h01 : 8'h00);
    end
  endtask

  task automatic t_power();
    h.power_up();
    @(posedge clk);
    #1;
    c = dflt();
    c.display_on = 1'h1;
    chk(cfg, c);
    chk({logic_pwr, panel_pwr}, 2'h3);
    h.power_down();
    #1 chk(cfg.display_on, 1'h0);
    chk({logic_pwr, panel_pwr}, 2'h0);
  endtask

  // Every field, a write to status, then two reads with an idle cycle between
  task automatic t_write();
    h.put(CTRL_OFS, 8'h7F);
    h.put(GLYPH_OFS, 8'hFF);
    h.put(ICON_OFS, 8'h2A);
    h.put(TEXT_OFS, 8'h55);
    h.put(LINE_OFS, 8'h13);
    h.put(COL_OFS, 8'h7E);
    h.put(CONTRAST_OFS, 8'h55);
    h.put(STATUS_OFS, 8'h00);
    #1;
    c = '1;
    c.icon_addr = 6'h2A;
    c.text_addr = 7'h55;
    c.start_line = 7'h13;
    c.col_addr = 7'h7E;
    c.contrast = 8'h55;
    chk(cfg, c);
    h.get(GLYPH_OFS, rv);
    chk(rv, 8'h3F);
    h.get(STATUS_OFS, rv);
    chk(rv, 8'h01);
    @(posedge clk);
    #1 chk(rdata, 8'h00);
  endtask

  // Pin low mid-run: defaults after three edges, writes refused
  task automatic t_hold();
    h.pin(1'h0);
    repeat (2) @(posedge clk);
    #1 chk(cfg.contrast, 8'h55);
    @(posedge clk);
    #1 chk(cfg, dflt());
    chk(ready, 1'h0);
    h.put(CONTRAST_OFS, 8'h11);
    #1 chk(cfg, dflt());
    h.get(STATUS_OFS, rv);
    chk(rv, 8'h02);
    h.pin(1'h1);
    wait_ready();
    chk(n, 3);
    h.put(CONTRAST_OFS, 8'h11);
    #1 chk(cfg.contrast, 8'h11);
  endtask

  // Clock enable low freezes state
  task automatic t_clken();
    @(posedge clk);
    clk_en <= 1'h0;
    h.put(CONTRAST_OFS, 8'h22);
    clk_en <= 1'h1;
    #1 chk(cfg.contrast, 8'h11);
  endtask

  // Mid-run reset: defaults return, ready after three edges
  task automatic t_reset();
    h.put(CTRL_OFS, 8'h7F);
    @(posedge clk);
    nrst <= 1'h0;
    repeat (2) @(posedge clk);
    nrst <= 1'h1;
    #1 chk(cfg, dflt());
    chk(ready, 1'h0);
    wait_ready();
    chk(n, 3);
  endtask

  // Logic supply may only fall once the panel supply is off
  always @(negedge logic_pwr) begin
    if (nrst === 1'h1) begin
      chk(panel_pwr, 1'h0);
    end
  end

  // Watchdog well beyond the expected run of about 140 cycles
  initial begin
    #(8 * 20000);
    n_fail++;
    results();
  end

  initial begin
    nrst   = 1'h0;
    clk_en = 1'h1;
    repeat (12) @(posedge clk);
    nrst <= 1'h1;
    wait_ready();
    t_defaults();
    t_power();
    t_write();
    t_hold();
    t_clken();
    t_reset();
    results();
  end
endmodule // oled_char_reset_power_seq_test
